//--- rtl/rsfr_defs.vh
// Purpose: constants for the regulator set-point and LDO fault register block
// Assumes: 10 MHz system clock, byte-wide registers behind the serial control port
// Notes:   offsets are byte register addresses on the control port
`ifndef RSFR_DEFS_VH
`define RSFR_DEFS_VH

// Arbitrary neutral device address on the control port
`define RSFR_DEV_ADDR          7'h08

`define RSFR_ADDR_DDR_NORMAL   8'h3C
`define RSFR_ADDR_DDR_STBY     8'h3D
`define RSFR_ADDR_DDR_SLEEP    8'h3E
`define RSFR_ADDR_DDR_MODE     8'h3F
`define RSFR_ADDR_DDR_CONF     8'h40
`define RSFR_ADDR_BOOST_CTL    8'h66
`define RSFR_ADDR_LDO_EN       8'h70
`define RSFR_ADDR_LDO_FAULT    8'h71
`define RSFR_ADDR_LDO_MASK     8'h72
`define RSFR_ADDR_LDO_PROT     8'h73

`define RSFR_RST_DDR_VCODE     4'h0
`define RSFR_RST_DDR_MODE      8'h00
`define RSFR_RST_DDR_CONF      8'h00
`define RSFR_RST_BOOST_VOLT    2'b00
`define RSFR_RST_BOOST_MODE    2'b10
`define RSFR_RST_LDO_EN        6'b00_0000
`define RSFR_RST_LDO_MASK      6'b00_0000

`define RSFR_MODE_OFF          2'b00
`define RSFR_MODE_PFM          2'b01
`define RSFR_MODE_AUTO         2'b10
`define RSFR_MODE_PSKIP        2'b11

`define RSFR_NUM_LDO           6
`define RSFR_PROT_EN_BIT       0

// Overload time in microseconds and clock rate in MHz
`define RSFR_OVLD_TIME_US      8000
`define RSFR_CLK_MHZ           10
`define RSFR_OVLD_CYCLES       (`RSFR_OVLD_TIME_US * `RSFR_CLK_MHZ)

`endif

//--- rtl/rsfr_i2c_slave.v
// Purpose: byte-level serial control port slave with register pointer and auto-increment
// Assumes: scl_i and sda_i already synchronous to clk_i; scl well below clk_i rate
// Notes:   write: addr+W, pointer, data...; read: addr+R returns data at pointer onward
module rsfr_i2c_slave #(
	parameter [6:0] DEV_ADDR = 7'h08
) (
	input  wire       clk_i,
	input  wire       resetn_i,
	input  wire       scl_i,
	input  wire       sda_i,
	output reg        sda_o,
	output reg        sda_oe_o,
	input  wire [7:0] rd_data_i,
	output wire [7:0] rd_addr_o,
	output reg        wr_stb_o,
	output reg  [7:0] wr_addr_o,
	output reg  [7:0] wr_data_o
);
	localparam [2:0] ST_IDLE = 3'd0;
	localparam [2:0] ST_ADDR = 3'd1;
	localparam [2:0] ST_PTR  = 3'd2;
	localparam [2:0] ST_WDAT = 3'd3;
	localparam [2:0] ST_ACK  = 3'd4;
	localparam [2:0] ST_RDAT = 3'd5;
	localparam [2:0] ST_RACK = 3'd6;

	reg       scl_d_ff;
	reg       sda_d_ff;
	reg [2:0] state_ff;
	reg [2:0] tgt_ff;
	reg [3:0] bitcnt_ff;
	reg [7:0] shreg_ff;
	reg [7:0] ptr_ff;

	wire scl_rise = scl_i & ~scl_d_ff;
	wire scl_fall = ~scl_i & scl_d_ff;
	wire start_ev = scl_i & scl_d_ff & sda_d_ff & ~sda_i;
	wire stop_ev  = scl_i & scl_d_ff & ~sda_d_ff & sda_i;

	assign rd_addr_o = ptr_ff;

	always @(posedge clk_i) begin
		wr_stb_o <= 1'b0;
		if (!resetn_i) begin
			scl_d_ff  <= 1'b1;
			sda_d_ff  <= 1'b1;
			state_ff  <= ST_IDLE;
			tgt_ff    <= ST_IDLE;
			bitcnt_ff <= 4'h0;
			shreg_ff  <= 8'h00;
			ptr_ff    <= 8'h00;
			sda_o     <= 1'b0;
			sda_oe_o  <= 1'b0;
			wr_addr_o <= 8'h00;
			wr_data_o <= 8'h00;
		end else begin
			scl_d_ff <= scl_i;
			sda_d_ff <= sda_i;
			if (start_ev) begin
				state_ff  <= ST_ADDR;
				bitcnt_ff <= 4'h0;
				sda_oe_o  <= 1'b0;
			end else if (stop_ev) begin
				state_ff <= ST_IDLE;
				sda_oe_o <= 1'b0;
			end else if (scl_rise) begin
				case (state_ff)
					ST_ADDR, ST_PTR, ST_WDAT: begin
						shreg_ff  <= {shreg_ff[6:0], sda_i};
						bitcnt_ff <= bitcnt_ff + 4'h1;
					end
					ST_RDAT: begin
						bitcnt_ff <= bitcnt_ff + 4'h1;
					end
					ST_RACK: begin
						// A not-acknowledge ends the read burst
						if (sda_i)
							state_ff <= ST_IDLE;
					end
					default: begin
					end
				endcase
			end else if (scl_fall) begin
				case (state_ff)
					ST_ADDR: begin
						if (bitcnt_ff == 4'h8) begin
							if (shreg_ff[7:1] == DEV_ADDR) begin
								sda_o    <= 1'b0;
								sda_oe_o <= 1'b1;
								state_ff <= ST_ACK;
								tgt_ff   <= shreg_ff[0] ? ST_RDAT : ST_PTR;
							end else begin
								state_ff <= ST_IDLE;
							end
						end
					end
					ST_PTR, ST_WDAT: begin
						if (bitcnt_ff == 4'h8) begin
							sda_o    <= 1'b0;
							sda_oe_o <= 1'b1;
							state_ff <= ST_ACK;
							tgt_ff   <= ST_WDAT;
							if (state_ff == ST_PTR) begin
								ptr_ff <= shreg_ff;
							end else begin
								wr_stb_o  <= 1'b1;
								wr_addr_o <= ptr_ff;
								wr_data_o <= shreg_ff;
								ptr_ff    <= ptr_ff + 8'h01;
							end
						end
					end
					ST_ACK, ST_RACK: begin
						bitcnt_ff <= 4'h0;
						if (state_ff == ST_RACK || tgt_ff == ST_RDAT) begin
							shreg_ff <= rd_data_i;
							sda_o    <= rd_data_i[7];
							sda_oe_o <= ~rd_data_i[7];
							state_ff <= ST_RDAT;
						end else begin
							sda_oe_o <= 1'b0;
							state_ff <= tgt_ff;
						end
					end
					ST_RDAT: begin
						if (bitcnt_ff == 4'h8) begin
							sda_oe_o <= 1'b0;
							state_ff <= ST_RACK;
							ptr_ff   <= ptr_ff + 8'h01;
						end else begin
							// Open drain: only a zero is driven
							shreg_ff <= {shreg_ff[6:0], 1'b0};
							sda_o    <= shreg_ff[6];
							sda_oe_o <= ~shreg_ff[6];
						end
					end
					default: begin
						sda_oe_o <= 1'b0;
					end
				endcase
			end
		end
	end
endmodule

//--- rtl/rsfr_regs.v
// Purpose: DDR buck and boost set-point registers plus LDO overload shutdown and fault flags
// Assumes: all inputs synchronous to clk_i; one LDO current-limit level per LDO
// Notes:   registers are reached only through the serial control port pins
`include "rsfr_defs.vh"

module rsfr_regs #(
	parameter [6:0]  DEV_ADDR    = `RSFR_DEV_ADDR,
	parameter [31:0] OVLD_CYCLES = `RSFR_OVLD_CYCLES
) (
	input  wire       clk_i,
	input  wire       resetn_i,
	input  wire       scl_i,
	input  wire       sda_i,
	output wire       sda_o,
	output wire       sda_oe_o,
	input  wire       standby_i,
	input  wire       sleep_i,
	input  wire [5:0] ldo_current_limit_setting_i,
	input  wire [2:0] boost_powerup_slot_i,
	output reg  [3:0] ddr_buck_vcode_o,
	output reg  [7:0] ddr_buck_mode_o,
	output reg  [7:0] ddr_buck_config_o,
	output reg  [1:0] boost_voltage_code_o,
	output reg  [1:0] boost_active_mode_o,
	output reg        boost_in_powerup_o,
	output reg  [5:0] ldo_enable_bit_o,
	output reg  [5:0] ldo_fault_flag_o,
	output reg        ldo_fault_irq_o
);
	localparam [16:0] OVLD_LIMIT = OVLD_CYCLES[16:0];

	wire       wr_stb;
	wire [7:0] wr_addr;
	wire [7:0] wr_data;
	wire [7:0] rd_addr;
	reg  [7:0] rd_data;

	reg  [3:0] ddr_normal_ff;
	reg  [3:0] ddr_stby_ff;
	reg  [3:0] ddr_sleep_ff;
	reg  [7:0] ddr_mode_ff;
	reg  [7:0] ddr_conf_ff;
	reg  [1:0] boost_volt_ff;
	reg  [1:0] boost_stby_mode_ff;
	reg  [5:0] ldo_mask_ff;
	reg        prot_en_ff;
	reg        strap_taken_ff;
	reg [16:0] ovld_cnt_ff [0:5];
	reg  [5:0] trip;
	reg  [5:0] nxt_enable;
	reg  [5:0] nxt_fault;
	integer    i;
	// Separate index so the clocked and combinational loops never share a variable
	integer    k;

	// Write strobe for one register address
	function wr_hit;
		input       stb;
		input [7:0] addr;
		input [7:0] target;
		begin
			wr_hit = stb & (addr == target);
		end
	endfunction

	// Boost register image; reserved bits 7 and 4 read as zero
	function [7:0] boost_image;
		input [1:0] stby_mode;
		input [1:0] volt;
		begin
			boost_image = {1'b0, stby_mode, 1'b0, `RSFR_MODE_AUTO, volt};
		end
	endfunction

	rsfr_i2c_slave #(
		.DEV_ADDR (DEV_ADDR)
	) u_port (
		.clk_i     (clk_i),
		.resetn_i  (resetn_i),
		.scl_i     (scl_i),
		.sda_i     (sda_i),
		.sda_o     (sda_o),
		.sda_oe_o  (sda_oe_o),
		.rd_data_i (rd_data),
		.rd_addr_o (rd_addr),
		.wr_stb_o  (wr_stb),
		.wr_addr_o (wr_addr),
		.wr_data_o (wr_data)
	);

	// Set-point and mode registers
	always @(posedge clk_i) begin
		if (!resetn_i) begin
			ddr_normal_ff      <= `RSFR_RST_DDR_VCODE;
			ddr_stby_ff        <= `RSFR_RST_DDR_VCODE;
			ddr_sleep_ff       <= `RSFR_RST_DDR_VCODE;
			ddr_mode_ff        <= `RSFR_RST_DDR_MODE;
			ddr_conf_ff        <= `RSFR_RST_DDR_CONF;
			boost_volt_ff      <= `RSFR_RST_BOOST_VOLT;
			boost_stby_mode_ff <= `RSFR_RST_BOOST_MODE;
			ldo_mask_ff        <= `RSFR_RST_LDO_MASK;
			prot_en_ff         <= 1'b0;
		end else begin
			if (wr_hit(wr_stb, wr_addr, `RSFR_ADDR_DDR_NORMAL))
				ddr_normal_ff <= wr_data[3:0];
			if (wr_hit(wr_stb, wr_addr, `RSFR_ADDR_DDR_STBY))
				ddr_stby_ff <= wr_data[3:0];
			if (wr_hit(wr_stb, wr_addr, `RSFR_ADDR_DDR_SLEEP))
				ddr_sleep_ff <= wr_data[3:0];
			if (wr_hit(wr_stb, wr_addr, `RSFR_ADDR_DDR_MODE))
				ddr_mode_ff <= wr_data;
			if (wr_hit(wr_stb, wr_addr, `RSFR_ADDR_DDR_CONF))
				ddr_conf_ff <= wr_data;
			if (wr_hit(wr_stb, wr_addr, `RSFR_ADDR_BOOST_CTL)) begin
				boost_volt_ff      <= wr_data[1:0];
				boost_stby_mode_ff <= wr_data[6:5];
			end
			if (wr_hit(wr_stb, wr_addr, `RSFR_ADDR_LDO_MASK))
				ldo_mask_ff <= wr_data[5:0];
			if (wr_hit(wr_stb, wr_addr, `RSFR_ADDR_LDO_PROT))
				prot_en_ff <= wr_data[`RSFR_PROT_EN_BIT];
		end
	end

	// Read multiplexer; unmapped addresses read zero
	always @* begin
		case (rd_addr)
			`RSFR_ADDR_DDR_NORMAL: rd_data = {4'h0, ddr_normal_ff};
			`RSFR_ADDR_DDR_STBY:   rd_data = {4'h0, ddr_stby_ff};
			`RSFR_ADDR_DDR_SLEEP:  rd_data = {4'h0, ddr_sleep_ff};
			`RSFR_ADDR_DDR_MODE:   rd_data = ddr_mode_ff;
			`RSFR_ADDR_DDR_CONF:   rd_data = ddr_conf_ff;
			`RSFR_ADDR_BOOST_CTL:  rd_data = boost_image(boost_stby_mode_ff, boost_volt_ff);
			`RSFR_ADDR_LDO_EN:     rd_data = {2'b00, ldo_enable_bit_o};
			`RSFR_ADDR_LDO_FAULT:  rd_data = {2'b00, ldo_fault_flag_o};
			`RSFR_ADDR_LDO_MASK:   rd_data = {2'b00, ldo_mask_ff};
			`RSFR_ADDR_LDO_PROT:   rd_data = {7'h00, prot_en_ff};
			default:               rd_data = 8'h00;
		endcase
	end

	// Overload timers: counter stops at the limit so a long overload cannot wrap
	always @(posedge clk_i) begin
		for (i = 0; i < `RSFR_NUM_LDO; i = i + 1) begin
			if (!resetn_i) begin
				ovld_cnt_ff[i] <= 17'h0_0000;
			end else if (!ldo_current_limit_setting_i[i]) begin
				ovld_cnt_ff[i] <= 17'h0_0000;
			end else if (ovld_cnt_ff[i] != OVLD_LIMIT) begin
				ovld_cnt_ff[i] <= ovld_cnt_ff[i] + 17'h0_0001;
			end
		end
	end

	// Trip once the limit has already lasted OVLD_LIMIT cycles and persists
	always @* begin
		for (k = 0; k < `RSFR_NUM_LDO; k = k + 1) begin
			trip[k] = prot_en_ff & ldo_current_limit_setting_i[k] & (ovld_cnt_ff[k] == OVLD_LIMIT);
		end
	end

	// Enable and fault flag next values; hardware events win over software
	always @* begin
		nxt_enable = ldo_enable_bit_o;
		nxt_fault  = ldo_fault_flag_o;
		if (wr_hit(wr_stb, wr_addr, `RSFR_ADDR_LDO_EN))
			nxt_enable = wr_data[5:0];
		if (wr_hit(wr_stb, wr_addr, `RSFR_ADDR_LDO_FAULT))
			nxt_fault = nxt_fault & ~wr_data[5:0];
		nxt_enable = nxt_enable & ~trip;
		nxt_fault = nxt_fault | ldo_current_limit_setting_i | trip;
	end

	always @(posedge clk_i) begin
		if (!resetn_i) begin
			ldo_enable_bit_o <= `RSFR_RST_LDO_EN;
			ldo_fault_flag_o <= 6'b00_0000;
			ldo_fault_irq_o  <= 1'b0;
		end else begin
			ldo_enable_bit_o <= nxt_enable;
			ldo_fault_flag_o <= nxt_fault;
			ldo_fault_irq_o  <= |(nxt_fault & ~ldo_mask_ff);
		end
	end

	// Power-up membership and live regulator controls
	always @(posedge clk_i) begin
		if (!resetn_i) begin
			strap_taken_ff       <= 1'b0;
			boost_in_powerup_o   <= 1'b0;
			ddr_buck_vcode_o     <= `RSFR_RST_DDR_VCODE;
			ddr_buck_mode_o      <= `RSFR_RST_DDR_MODE;
			ddr_buck_config_o    <= `RSFR_RST_DDR_CONF;
			boost_voltage_code_o <= `RSFR_RST_BOOST_VOLT;
			boost_active_mode_o  <= `RSFR_MODE_AUTO;
		end else begin
			// slot captured once after reset release
			if (!strap_taken_ff) begin
				strap_taken_ff     <= 1'b1;
				boost_in_powerup_o <= |boost_powerup_slot_i;
			end
			// sleep has priority over standby when both are asserted
			if (sleep_i)
				ddr_buck_vcode_o <= ddr_sleep_ff;
			else if (standby_i)
				ddr_buck_vcode_o <= ddr_stby_ff;
			else
				ddr_buck_vcode_o <= ddr_normal_ff;
			ddr_buck_mode_o      <= ddr_mode_ff;
			ddr_buck_config_o    <= ddr_conf_ff;
			boost_voltage_code_o <= boost_volt_ff;
			// normal mode is fixed automatic; standby uses its field
			boost_active_mode_o  <= standby_i ? boost_stby_mode_ff : `RSFR_MODE_AUTO;
		end
	end
endmodule

//--- sim/rsfr_host.sv
// Purpose: host processor model driving the serial control port
// Assumes: sda_i is the resolved wire with pull-up; 4 clk per scl phase
// Notes:   byte_io always releases the ninth bit, so writes see ACK and reads send NACK; rd2 acknowledges its first byte
module rsfr_host #(
	parameter [6:0] DEV_ADDR = 7'h08
) (
	input  wire  clk_i,
	input  wire  sda_i,
	output logic scl_o,
	output logic sda_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic tk(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// Data only moves while scl is low
	task automatic bit_io(input logic b, output logic r);
		sda_o = b;
		tk(3);
		scl_o = 1'b1;
		tk(2);
		r = sda_i;
		tk(2);
		scl_o = 1'b0;
		tk(1);
	endtask
	task automatic byte_io(input logic [7:0] d, output logic [7:0] r);
		logic a;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r[i]);
		bit_io(1'b1, a);
	endtask
	task automatic start();
		sda_o = 1'b1;
		tk(3);
		scl_o = 1'b1;
		tk(4);
		sda_o = 1'b0;
		tk(4);
		scl_o = 1'b0;
		tk(1);
	endtask
	task automatic stop();
		sda_o = 1'b0;
		tk(3);
		scl_o = 1'b1;
		tk(4);
		sda_o = 1'b1;
		tk(4);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		start();
		byte_io({DEV_ADDR, 1'b0}, r);
		byte_io(a, r);
		byte_io(d, r);
		stop();
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] r);
		start();
		byte_io({DEV_ADDR, 1'b0}, r);
		byte_io(a, r);
		start();
		byte_io({DEV_ADDR, 1'b1}, r);
		byte_io(8'hff, r);
		stop();
	endtask
	// Two-byte bursts: the pointer steps after each byte
	task automatic wr2(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1);
		logic [7:0] r;
		start();
		byte_io({DEV_ADDR, 1'b0}, r);
		byte_io(a, r);
		byte_io(d0, r);
		byte_io(d1, r);
		stop();
	endtask
	task automatic rd2(input logic [7:0] a, output logic [7:0] r0, output logic [7:0] r1);
		logic [7:0] r;
		logic       k;
		start();
		byte_io({DEV_ADDR, 1'b0}, r);
		byte_io(a, r);
		start();
		byte_io({DEV_ADDR, 1'b1}, r);
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, r0[i]);
		// Host acknowledge keeps the read burst going
		bit_io(1'b0, k);
		byte_io(8'hff, r1);
		stop();
	endtask
endmodule

//--- sim/rsfr_regs_props.sv
// Purpose: port-level checks for the set-point and LDO fault register block
// Assumes: bench holds the serial bus idle (scl high) during overload pulses
// Notes:   trip timing is watched on LDO 0 only, to keep one helper counter
module rsfr_regs_chk #(
	parameter [31:0] OVLD_CYCLES = 80000
) (
	input logic       clk_i,
	input logic       resetn_i,
	input logic       scl_i,
	input logic       standby_i,
	input logic [5:0] ldo_current_limit_setting_i,
	input logic [2:0] boost_powerup_slot_i,
	input logic [1:0] boost_voltage_code_o,
	input logic [1:0] boost_active_mode_o,
	input logic       boost_in_powerup_o,
	input logic [5:0] ldo_enable_bit_o,
	input logic [5:0] ldo_fault_flag_o,
	input logic       ldo_fault_irq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] ovld_cnt_ff;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// Consecutive limit cycles on LDO 0
	always_ff @(posedge clk_i) begin
		if (!resetn_i || !ldo_current_limit_setting_i[0])
			ovld_cnt_ff <= 32'h0000_0000;
		else
			ovld_cnt_ff <= ovld_cnt_ff + 32'h0000_0001;
	end
	property p_trip_time;
		$fell(ldo_enable_bit_o[0]) && $past(scl_i) |->
			$past(ovld_cnt_ff) == OVLD_CYCLES && $past(ldo_current_limit_setting_i[0]);
	endproperty
	a_trip_time: assert property (p_trip_time) else $error("trip not at limit time");
	property p_trip_flag;
		$fell(ldo_enable_bit_o[0]) && $past(scl_i) |-> ldo_fault_flag_o[0];
	endproperty
	a_trip_flag: assert property (p_trip_flag) else $error("trip without flag");
	property p_flag_set;
		ldo_current_limit_setting_i != 6'h00 |=> (ldo_fault_flag_o & $past(ldo_current_limit_setting_i)) == $past(ldo_current_limit_setting_i);
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("overload left flag clear");
	property p_flag_sticky;
		|($past(ldo_fault_flag_o) & ~ldo_fault_flag_o) |-> !$past(scl_i)
			&& ($past(ldo_fault_flag_o) & ~ldo_fault_flag_o & $past(ldo_current_limit_setting_i)) == 6'h00;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped by itself");
	property p_enable_rise;
		|(ldo_enable_bit_o & ~$past(ldo_enable_bit_o)) |-> !$past(scl_i);
	endproperty
	a_enable_rise: assert property (p_enable_rise) else $error("enable rose unasked");
	property p_irq_quiet;
		ldo_fault_flag_o == 6'h00 |-> !ldo_fault_irq_o;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("irq without flag");
	property p_powerup;
		$past(resetn_i, 2) |-> boost_in_powerup_o == (|boost_powerup_slot_i);
	endproperty
	a_powerup: assert property (p_powerup) else $error("power-up inclusion wrong");
	property p_auto_normal;
		!standby_i |=> boost_active_mode_o == 2'b10;
	endproperty
	a_auto_normal: assert property (p_auto_normal) else $error("normal mode not auto");
	property p_reset_vals;
		!$past(resetn_i) |-> boost_voltage_code_o == 2'b00 && ldo_enable_bit_o == 6'h00;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");
	c_trip: cover property ($fell(ldo_enable_bit_o[0]));
	c_irq: cover property (ldo_fault_irq_o);
	c_stby: cover property (standby_i ##1 boost_active_mode_o == 2'b01);
endmodule

bind rsfr_regs rsfr_regs_chk #(.OVLD_CYCLES(OVLD_CYCLES)) rsfr_regs_chk_i (
	.clk_i(clk_i), .resetn_i(resetn_i), .scl_i(scl_i), .standby_i(standby_i),
	.ldo_current_limit_setting_i(ldo_current_limit_setting_i), .boost_powerup_slot_i(boost_powerup_slot_i),
	.boost_voltage_code_o(boost_voltage_code_o), .boost_active_mode_o(boost_active_mode_o),
	.boost_in_powerup_o(boost_in_powerup_o), .ldo_enable_bit_o(ldo_enable_bit_o),
	.ldo_fault_flag_o(ldo_fault_flag_o), .ldo_fault_irq_o(ldo_fault_irq_o));

//--- sim/testbench.sv
// Purpose: self-checking bench for the set-point and LDO fault register block
// Assumes: overload time shortened to OVLD cycles
// Notes:   integer model of every register, compared on each read-back and output check
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int OVLD = 20;
	logic       clk_i, resetn_i, standby_i, sleep_i;
	logic [5:0] current_limit_setting;
	logic [2:0] slot;
	logic [7:0] rd;
	logic [31:0] rng = 32'd65738;
	logic [7:0] ra [6] = '{8'h3c, 8'h3d, 8'h3e, 8'h3f, 8'h40, 8'h66};
	wire        scl, sda_h, sda_o, sda_oe, bpu, irq;
	wire        sda_w = sda_oe ? sda_o : sda_h;
	wire [3:0]  vcode;
	wire [7:0]  dmode, dconf;
	wire [1:0]  bvolt, bmode;
	wire [5:0]  en, flg;
	int         num_errors, n_tests, men, mflg, mmask;
	int         mreg [256];
	rsfr_host rsfr_host_i (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_h));
	rsfr_regs #(.OVLD_CYCLES(OVLD)) rsfr_regs_i (
		.clk_i(clk_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe_o(sda_oe), .standby_i(standby_i), .sleep_i(sleep_i), .ldo_current_limit_setting_i(current_limit_setting),
		.boost_powerup_slot_i(slot), .ddr_buck_vcode_o(vcode), .ddr_buck_mode_o(dmode),
		.ddr_buck_config_o(dconf), .boost_voltage_code_o(bvolt), .boost_active_mode_o(bmode),
		.boost_in_powerup_o(bpu), .ldo_enable_bit_o(en), .ldo_fault_flag_o(flg),
		.ldo_fault_irq_o(irq));
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	function automatic logic [7:0] exp_rd(input int a);
		case (a)
			8'h3c, 8'h3d, 8'h3e: return 8'(mreg[a] & 15);
			8'h3f, 8'h40: return 8'(mreg[a]);
			8'h66: return 8'((mreg[a] & 8'h63) | 8'h08);
			8'h70: return 8'(men);
			8'h71: return 8'(mflg);
			8'h72: return 8'(mmask);
			8'h73: return 8'(mreg[a] & 1);
			default: return 8'h00;
		endcase
	endfunction
	task automatic summarize();
		if (num_errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic rst(input logic [2:0] s);
		resetn_i = 1'b0;
		slot = s;
		repeat (2) @(posedge clk_i);
		#1 resetn_i = 1'b1;
		foreach (mreg[i]) mreg[i] = 0;
		mreg[8'h66] = 8'h40;
		{men, mflg, mmask} = 0;
		repeat (2) @(posedge clk_i);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		rsfr_host_i.wr(a, d);
		mdl(a, d);
	endtask
	task automatic mdl(input logic [7:0] a, input logic [7:0] d);
		mreg[a] = d;
		if (a == 8'h70) men = d & 8'h3f;
		if (a == 8'h71) mflg &= ~d;
		if (a == 8'h72) mmask = d & 8'h3f;
	endtask
	task automatic rdchk(input logic [7:0] a);
		rsfr_host_i.rd(a, rd);
		`CHK(rd, exp_rd(a))
	endtask
	task automatic outchk();
		int v;
		v = sleep_i ? mreg[8'h3e] : standby_i ? mreg[8'h3d] : mreg[8'h3c];
		`CHK(vcode, 4'(v))
		`CHK(dmode, 8'(mreg[8'h3f]))
		`CHK(dconf, 8'(mreg[8'h40]))
		`CHK(bvolt, 2'(mreg[8'h66]))
		`CHK(bmode, standby_i ? 2'(mreg[8'h66] >> 5) : 2'b10)
		`CHK(en, 6'(men))
		`CHK(flg, 6'(mflg))
		`CHK(irq, |6'(mflg & ~mmask))
	endtask
	task automatic ovl(input int n, input int k);
		current_limit_setting[k] = 1'b1;
		repeat (n) @(posedge clk_i);
		#1 current_limit_setting[k] = 1'b0;
		mflg |= 1 << k;
		if ((mreg[8'h73] & 1) && n > OVLD) men &= ~(1 << k);
		@(posedge clk_i);
		#1 outchk();
	endtask
	initial begin
		repeat (100000) @(posedge clk_i);
		num_errors++;
		summarize();
	end
	initial begin
		logic [31:0] d;
		logic [7:0]  r1;
		{resetn_i, standby_i, sleep_i, current_limit_setting, slot, num_errors, n_tests} = 0;
		rst(3'b000);
		`CHK(bpu, 1'b0)
		rst(3'b101);
		`CHK(bpu, 1'b1)
		foreach (ra[i]) rdchk(ra[i]);
		for (int k = 0; k < 12; k++) begin
			d = xs();
			wr(ra[k % 6], d[7:0]);
		end
		foreach (ra[i]) rdchk(ra[i]);
		rdchk(8'h50);
		d = xs();
		rsfr_host_i.wr2(8'h3c, d[7:0], d[15:8]);
		mdl(8'h3c, d[7:0]);
		mdl(8'h3d, d[15:8]);
		rsfr_host_i.rd2(8'h3c, rd, r1);
		`CHK(rd, exp_rd(8'h3c))
		`CHK(r1, exp_rd(8'h3d))
		for (int m = 0; m < 8; m++) begin
			d = xs();
			wr(8'h66, {d[7], 2'(m), d[4:0]});
			standby_i = ~m[2];
			sleep_i = m[0];
			repeat (2) @(posedge clk_i);
			#1 outchk();
		end
		{standby_i, sleep_i} = 0;
		wr(8'h70, 8'h3f);
		ovl(OVLD + 5, 0);
		wr(8'h71, 8'h01);
		rdchk(8'h71);
		wr(8'h73, 8'h01);
		ovl(OVLD, 0);
		ovl(OVLD, 0);
		ovl(OVLD + 1, 0);
		wr(8'h72, 8'h01);
		outchk();
		wr(8'h71, 8'h01);
		wr(8'h70, 8'h3f);
		outchk();
		ovl(OVLD + 1, 1 + int'(xs() % 5));
		wr(8'h72, 8'h3f);
		outchk();
		summarize();
	end
endmodule
